// File: logic/hcs_host_config_select.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
// Contract
// - reset disables every extension function; behaves as plain adapter
// - extension control writes ignored unless both enable groups set; id writes always taken; groups clear on reset
// - standard registers get no extended meaning in unused bits
// - strap picks isa-style or channel-bus host signalling, both on chip
// - host transfers may be 8 or 16 bits wide
// - isa mode decodes bios rom, drives rom select and transceiver enable
// - seven switches multiplexed on bus inputs, read through buffers
// - switch states captured into readable register while command strobe low
// - up to sixteen devices share space; only selected one responds
// - written id must equal own switch number to respond
// - 256 KB display memory as four 64 KB planes of two chips
// - misc output bits 2 and 3 pick one of three dot clocks
// - io sequencing on memory clock, dram timing on selected dot clock (dram outputs here are registered on mclk, dot clock only driven out)
// - strap low selects channel bus, high selects isa-style
// - upper address to switch bits 0-2, byte-high 3, high-address 4
// - memory-io input to switch bit 5, refresh or disable to bit 6
// - refresh or disable low blocks all memory and io responses
module hcs_host_config_select (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_type_strap,
  input wire logic high_byte_enable_n,
  input wire logic refresh_cycle_n,
  input wire logic mem_or_io_sel,
  input wire logic [2:0] upper_addr,
  input wire logic high_address_valid,
  input wire logic cmd_strobe_n,
  input wire logic mem_read_n,
  input wire logic host_addr15,
  input wire logic [17:0] mem_offset,
  input wire logic dot_clock_a,
  input wire logic dot_clock_b,
  input wire logic dot_clock_c,
  output logic dot_clock_sel,
  output logic isa_mode,
  output logic host_respond,
  output logic wide_transfer,
  output logic bios_rom_select_n,
  output logic xcvr_enable_n,
  output logic [7:0] ext_features,
  output logic [6:0] switch_value,
  output logic [1:0] dram_plane,
  output logic [15:0] dram_addr,
  output logic [7:0] dram_chip_en
);

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == hcs_pkg::OFS_MISC_OUT) || (a == hcs_pkg::OFS_ENA_A) ||
                  (a == hcs_pkg::OFS_ENA_B) || (a == hcs_pkg::OFS_EXT_ID) ||
                  (a == hcs_pkg::OFS_SWITCH) || (a == hcs_pkg::OFS_EXT_CTRL) ||
                  (a == hcs_pkg::OFS_STATUS);
  endfunction

  function automatic hcs_pkg::hcs_dram_t plane_map(input logic [17:0] ofs);
    hcs_pkg::hcs_dram_t d;
    d.plane = ofs[17:16];
    d.addr = ofs[15:0];
    d.chip_en = '0;
    d.chip_en[2*ofs[17:16]] = 1'b1;
    d.chip_en[2*ofs[17:16]+1] = 1'b1;
    plane_map = d;
  endfunction

  hcs_pkg::hcs_pins_t pins_raw;
  hcs_pkg::hcs_pins_t pins_s;
  logic [hcs_pkg::PIN_W-1:0] pins_vec;

  assign pins_raw = '{strap: bus_type_strap, high_byte_enable_n: high_byte_enable_n,
                      refresh_cycle_n: refresh_cycle_n, mem_or_io_sel: mem_or_io_sel,
                      upper_addr: upper_addr, high_address_valid: high_address_valid,
                      cmd_strobe_n: cmd_strobe_n, mem_read_n: mem_read_n,
                      host_addr15: host_addr15};

  hcs_pin_sync #(
    .W(hcs_pkg::PIN_W),
    .INIT(hcs_pkg::PINS_INIT)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pin_in(pins_raw),
    .pin_out(pins_vec)
  );

  assign pins_s = hcs_pkg::hcs_pins_t'(pins_vec);

  // register state
  logic [7:0] misc_r, misc_nxt;
  logic ena_a_r, ena_a_nxt;
  logic ena_b_r, ena_b_nxt;
  logic [3:0] ext_id_r, ext_id_nxt;
  logic id_valid_r, id_valid_nxt;
  logic [7:0] ext_ctrl_r, ext_ctrl_nxt;
  logic [6:0] switch_r, switch_nxt;
  logic isa_r, isa_nxt;
  logic strap_done_r, strap_done_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic resp_r, resp_nxt;
  logic wide_r, wide_nxt;
  logic rom_n_r, rom_n_nxt;
  hcs_pkg::hcs_dram_t dram_r, dram_nxt;

  logic setup_ph;
  logic wr_acc;
  logic ext_open;
  logic selected;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && addr_mapped(paddr);
  assign ext_open = ena_a_r && ena_b_r;
  // before any id is written, a lone board answers
  assign selected = !id_valid_r || (ext_id_r == switch_r[3:0]);

  always_comb begin
    misc_nxt = misc_r;
    ena_a_nxt = ena_a_r;
    ena_b_nxt = ena_b_r;
    ext_id_nxt = ext_id_r;
    id_valid_nxt = id_valid_r;
    ext_ctrl_nxt = ext_ctrl_r;
    if (wr_acc) begin
      unique case (paddr)
        hcs_pkg::OFS_MISC_OUT: misc_nxt = pwdata[7:0];
        hcs_pkg::OFS_ENA_A: ena_a_nxt = pwdata[hcs_pkg::ENA_BIT];
        hcs_pkg::OFS_ENA_B: ena_b_nxt = pwdata[hcs_pkg::ENA_BIT];
        hcs_pkg::OFS_EXT_ID: begin
          // every device takes the id, selected or not
          ext_id_nxt = pwdata[hcs_pkg::ID_LSB +: hcs_pkg::ID_W];
          id_valid_nxt = 1'b1;
        end
        hcs_pkg::OFS_EXT_CTRL: begin
          if (ext_open) begin
            ext_ctrl_nxt = pwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // switch capture while command strobe low
  always_comb begin
    switch_nxt = switch_r;
    if (!pins_s.cmd_strobe_n) begin
      switch_nxt[2:0] = pins_s.upper_addr;
      switch_nxt[3] = pins_s.high_byte_enable_n;
      switch_nxt[4] = pins_s.high_address_valid;
      switch_nxt[5] = pins_s.mem_or_io_sel;
      switch_nxt[6] = pins_s.refresh_cycle_n;
    end
  end

  // strap taken once, first cycle after reset release
  always_comb begin
    isa_nxt = isa_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r) begin
      isa_nxt = pins_s.strap;
    end
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_ph) begin
      prdata_nxt = '0;
      unique case (paddr)
        hcs_pkg::OFS_MISC_OUT: prdata_nxt[7:0] = misc_r;
        hcs_pkg::OFS_ENA_A: prdata_nxt[hcs_pkg::ENA_BIT] = ena_a_r;
        hcs_pkg::OFS_ENA_B: prdata_nxt[hcs_pkg::ENA_BIT] = ena_b_r;
        hcs_pkg::OFS_EXT_ID: prdata_nxt[hcs_pkg::ID_LSB +: hcs_pkg::ID_W] = ext_id_r;
        hcs_pkg::OFS_SWITCH: prdata_nxt[6:0] = switch_r;
        hcs_pkg::OFS_EXT_CTRL: prdata_nxt[7:0] = ext_ctrl_r;
        hcs_pkg::OFS_STATUS: begin
          prdata_nxt[hcs_pkg::ST_ISA] = isa_r;
          prdata_nxt[hcs_pkg::ST_SELECTED] = selected;
          prdata_nxt[hcs_pkg::ST_RESPOND] = resp_r;
          prdata_nxt[hcs_pkg::ST_ID_VALID] = id_valid_r;
          prdata_nxt[hcs_pkg::ST_EXT_OPEN] = ext_open;
        end
        default: begin
        end
      endcase
    end
  end

  // host side gating and decode
  always_comb begin
    resp_nxt = selected && pins_s.refresh_cycle_n;
    wide_nxt = resp_nxt && !pins_s.high_byte_enable_n;
    rom_n_nxt = !(resp_nxt && isa_r && strap_done_r && !pins_s.mem_read_n &&
                  pins_s.high_address_valid && (pins_s.upper_addr == hcs_pkg::ROM_UPPER) &&
                  (pins_s.host_addr15 == hcs_pkg::ROM_A15));
    dram_nxt = plane_map(mem_offset);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      misc_r <= hcs_pkg::MISC_RST;
      ena_a_r <= 1'b0;
      ena_b_r <= 1'b0;
      ext_id_r <= hcs_pkg::ID_RST;
      id_valid_r <= 1'b0;
      ext_ctrl_r <= hcs_pkg::EXT_CTRL_RST;
      switch_r <= hcs_pkg::SW_RST;
      isa_r <= 1'b1;
      strap_done_r <= 1'b0;
      prdata_r <= '0;
      resp_r <= 1'b0;
      wide_r <= 1'b0;
      rom_n_r <= 1'b1;
      dram_r <= '0;
    end else begin
      misc_r <= misc_nxt;
      ena_a_r <= ena_a_nxt;
      ena_b_r <= ena_b_nxt;
      ext_id_r <= ext_id_nxt;
      id_valid_r <= id_valid_nxt;
      ext_ctrl_r <= ext_ctrl_nxt;
      switch_r <= switch_nxt;
      isa_r <= isa_nxt;
      strap_done_r <= strap_done_nxt;
      prdata_r <= prdata_nxt;
      resp_r <= resp_nxt;
      wide_r <= wide_nxt;
      rom_n_r <= rom_n_nxt;
      dram_r <= dram_nxt;
    end
  end

  // dot clock mux; select changes may glitch, reprogram only while blanked
  always_comb begin
    unique case (misc_r[hcs_pkg::MISC_CLK_LSB +: 2])
      hcs_pkg::CLK_SEL_A: dot_clock_sel = dot_clock_a;
      hcs_pkg::CLK_SEL_B: dot_clock_sel = dot_clock_b;
      default: dot_clock_sel = dot_clock_c;
    endcase
  end
  // dram plane, address and chip enables are registered on mclk like the register side; dot_clock_sel is only driven out

  assign prdata = prdata_r;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign isa_mode = isa_r;
  assign host_respond = resp_r;
  assign wide_transfer = wide_r;
  assign bios_rom_select_n = rom_n_r;
  assign xcvr_enable_n = rom_n_r;
  assign ext_features = ext_ctrl_r & {8{ext_open}};
  assign switch_value = switch_r;
  assign dram_plane = dram_r.plane;
  assign dram_addr = dram_r.addr;
  assign dram_chip_en = dram_r.chip_en;

  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && (paddr == a);
  endsequence

  property p_ext_reset_clear;
    @(posedge mclk) rstn && $past(!rstn) |-> (ext_features == 8'h00) && !ext_open;
  endproperty
  a_ext_reset_clear: assert property (p_ext_reset_clear) else $error("ext not cleared");

  property p_ext_gated;
    @(posedge mclk) disable iff (!rstn)
      s_wr(hcs_pkg::OFS_EXT_CTRL) ##0 !ext_open |=> $stable(ext_ctrl_r);
  endproperty
  a_ext_gated: assert property (p_ext_gated) else $error("gated ext write took");

  property p_ext_open_wr;
    @(posedge mclk) disable iff (!rstn)
      s_wr(hcs_pkg::OFS_EXT_CTRL) ##0 ext_open |=> ext_ctrl_r == $past(pwdata[7:0]);
  endproperty
  a_ext_open_wr: assert property (p_ext_open_wr) else $error("open ext write lost");

  property p_misc_isolated;
    @(posedge mclk) disable iff (!rstn) s_wr(hcs_pkg::OFS_MISC_OUT) |=> $stable(ext_ctrl_r);
  endproperty
  a_misc_isolated: assert property (p_misc_isolated) else $error("misc hit ext");

  property p_strap;
    @(posedge mclk) disable iff (!rstn) $rose(strap_done_r) |-> isa_mode == $past(pins_s.strap);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not taken");

  property p_disable_blocks;
    @(posedge mclk) disable iff (!rstn)
      !pins_s.refresh_cycle_n |=> !host_respond && bios_rom_select_n && !wide_transfer;
  endproperty
  a_disable_blocks: assert property (p_disable_blocks) else $error("responded while off");

  property p_sw_low;
    @(posedge mclk) disable iff (!rstn)
      !pins_s.cmd_strobe_n |=> switch_value[4:0] ==
        {$past(pins_s.high_address_valid), $past(pins_s.high_byte_enable_n),
         $past(pins_s.upper_addr)};
  endproperty
  a_sw_low: assert property (p_sw_low) else $error("switch bits 0-4 wrong");

  property p_sw_high;
    @(posedge mclk) disable iff (!rstn)
      !pins_s.cmd_strobe_n |=> switch_value[6:5] ==
        {$past(pins_s.refresh_cycle_n), $past(pins_s.mem_or_io_sel)};
  endproperty
  a_sw_high: assert property (p_sw_high) else $error("switch bits 5-6 wrong");

  property p_sw_hold;
    @(posedge mclk) disable iff (!rstn) pins_s.cmd_strobe_n |=> $stable(switch_value);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("switch moved");

  property p_id_mismatch;
    @(posedge mclk) disable iff (!rstn)
      s_wr(hcs_pkg::OFS_EXT_ID) ##1 (ext_id_r != switch_r[3:0]) [*2] |=> !host_respond;
  endproperty
  a_id_mismatch: assert property (p_id_mismatch) else $error("unselected responded");

  property p_rom_isa;
    @(posedge mclk) disable iff (!rstn) !bios_rom_select_n |-> isa_mode && !xcvr_enable_n;
  endproperty
  a_rom_isa: assert property (p_rom_isa) else $error("rom select outside isa");

  property p_clk_a;
    @(posedge mclk) disable iff (!rstn)
      (misc_r[3:2] == hcs_pkg::CLK_SEL_A) |-> dot_clock_sel == dot_clock_a;
  endproperty
  a_clk_a: assert property (p_clk_a) else $error("dot clock a not chosen");

  property p_plane;
    @(posedge mclk) disable iff (!rstn)
      1'b1 |=> dram_plane == $past(mem_offset[17:16]) && $countones(dram_chip_en) == 2;
  endproperty
  a_plane: assert property (p_plane) else $error("plane map wrong");

  property p_apb_answer;
    @(posedge mclk) disable iff (!rstn) setup_ph |=> (penable -> pready);
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb no answer");

endmodule

// File: pkg/hcs_pkg.sv
package hcs_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_MISC_OUT = 8'h00;
  localparam logic [7:0] OFS_ENA_A = 8'h04;
  localparam logic [7:0] OFS_ENA_B = 8'h08;
  localparam logic [7:0] OFS_EXT_ID = 8'h0C;
  localparam logic [7:0] OFS_SWITCH = 8'h10;
  localparam logic [7:0] OFS_EXT_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // field positions
  localparam int MISC_CLK_LSB = 2;
  localparam int ENA_BIT = 0;
  localparam int ID_LSB = 0;
  localparam int ID_W = 4;
  localparam int ST_ISA = 0;
  localparam int ST_SELECTED = 1;
  localparam int ST_RESPOND = 2;
  localparam int ST_ID_VALID = 3;
  localparam int ST_EXT_OPEN = 4;
  localparam int SW_W = 7;
  localparam int PIN_W = 11;

  // reset values
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [3:0] ID_RST = 4'h0;
  localparam logic [6:0] SW_RST = 7'h7F;
  localparam logic [PIN_W-1:0] PINS_INIT = 11'h706;

  // dot clock choices
  localparam logic [1:0] CLK_SEL_A = 2'h0;
  localparam logic [1:0] CLK_SEL_B = 2'h1;

  // bios rom window: upper address lines and address bit 15
  localparam logic [2:0] ROM_UPPER = 3'h4;
  localparam logic ROM_A15 = 1'h0;

  // display memory: four planes of 64 KB, two x4 chips each
  localparam int PLANES = 4;
  localparam int PLANE_AW = 16;
  localparam int MEM_AW = 18;
  localparam int CHIPS = 8;

  typedef struct packed {
    logic strap;
    logic high_byte_enable_n;
    logic refresh_cycle_n;
    logic mem_or_io_sel;
    logic [2:0] upper_addr;
    logic high_address_valid;
    logic cmd_strobe_n;
    logic mem_read_n;
    logic host_addr15;
  } hcs_pins_t;

  typedef struct packed {
    logic [1:0] plane;
    logic [PLANE_AW-1:0] addr;
    logic [CHIPS-1:0] chip_en;
  } hcs_dram_t;

endpackage

// File: logic/hcs_pin_sync.sv
`timescale 1ns/1ps
module hcs_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
      end
    end
  endgenerate

  // the filter runs through reset, so the levels are already settled at release
  // and a strap taken at the first edge afterwards is the real pin level
  always_ff @(posedge mclk) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    out_r <= out_nxt;
  end

  assign pin_out = out_r;

endmodule

// File: dv/hcs_host_model.sv
`timescale 1ns/1ps
module hcs_host_model (
  input wire logic mclk,
  input wire hcs_pkg::hcs_pins_t want,
  output hcs_pkg::hcs_pins_t pins,
  output logic dot_clock_a,
  output logic dot_clock_b,
  output logic dot_clock_c
);
  // pins and buffered switch levels change just after a clock edge
  always @(posedge mclk) pins <= want;
  // three unrelated dot clocks, scaled down for run length
  initial begin
    pins = want;
    dot_clock_a = 1'b0;
    dot_clock_b = 1'b0;
    dot_clock_c = 1'b0;
  end
  always #7.3 dot_clock_a = ~dot_clock_a;
  always #9.1 dot_clock_b = ~dot_clock_b;
  always #11.3 dot_clock_c = ~dot_clock_c;
endmodule

// File: dv/hcs_host_config_select_tb.sv
`timescale 1ns/1ps
module hcs_host_config_select_tb;
  logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, dot_clock_sel, isa_mode, host_respond, wide_transfer;
  logic bios_rom_select_n, xcvr_enable_n, ca, cb, cc;
  logic [7:0] ext_features, dram_chip_en;
  logic [6:0] switch_value;
  logic [1:0] dram_plane;
  logic [15:0] dram_addr;
  logic [17:0] mem_offset = 18'h0;
  logic [32:0] exp_q[$], e;
  logic [31:0] v;
  hcs_pkg::hcs_pins_t want = 11'h706, pins;
  int failures = 0, check_count = 0;
  always #50 mclk = ~mclk;
  hcs_host_model i_hcs_host_model (.mclk(mclk), .want(want), .pins(pins),
    .dot_clock_a(ca), .dot_clock_b(cb), .dot_clock_c(cc));
  hcs_host_config_select i_hcs_host_config_select (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_type_strap(pins.strap),
    .high_byte_enable_n(pins.high_byte_enable_n), .refresh_cycle_n(pins.refresh_cycle_n),
    .mem_or_io_sel(pins.mem_or_io_sel), .upper_addr(pins.upper_addr),
    .high_address_valid(pins.high_address_valid), .cmd_strobe_n(pins.cmd_strobe_n),
    .mem_read_n(pins.mem_read_n), .host_addr15(pins.host_addr15), .mem_offset(mem_offset),
    .dot_clock_a(ca), .dot_clock_b(cb), .dot_clock_c(cc), .dot_clock_sel(dot_clock_sel),
    .isa_mode(isa_mode), .host_respond(host_respond), .wide_transfer(wide_transfer),
    .bios_rom_select_n(bios_rom_select_n), .xcvr_enable_n(xcvr_enable_n),
    .ext_features(ext_features), .switch_value(switch_value), .dram_plane(dram_plane),
    .dram_addr(dram_addr), .dram_chip_en(dram_chip_en));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask
  task automatic rst();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    settle();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // read results are compared when the access completes
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({pslverr, prdata}, e);
    end
  end
  initial begin
    #2000000;
    failures++;
    test_done();
  end

  initial begin
    void'($urandom(32'hF46A));
    rst();
    rd(hcs_pkg::OFS_STATUS, 33'h07);
    rd(hcs_pkg::OFS_EXT_CTRL, 33'h0);
    chk(33'(ext_features), 33'h0);
    wr(hcs_pkg::OFS_EXT_CTRL, 32'hA5);
    rd(hcs_pkg::OFS_EXT_CTRL, 33'h0);
    wr(hcs_pkg::OFS_ENA_A, 32'h1);
    wr(hcs_pkg::OFS_EXT_CTRL, 32'hA5);
    rd(hcs_pkg::OFS_EXT_CTRL, 33'h0);
    wr(hcs_pkg::OFS_ENA_B, 32'h1);
    wr(hcs_pkg::OFS_EXT_CTRL, 32'h5A);
    rd(hcs_pkg::OFS_EXT_CTRL, 33'h5A);
    rd(hcs_pkg::OFS_STATUS, 33'h17);
    rd(8'h1C, 33'h1_0000_0000);
    wr(hcs_pkg::OFS_MISC_OUT, 32'hF3);
    chk(33'(ext_features), 33'h5A);
    rst();
    rd(hcs_pkg::OFS_EXT_CTRL, 33'h0);
    chk(33'(ext_features), 33'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      @(posedge mclk);
      {want.refresh_cycle_n, want.mem_or_io_sel, want.high_address_valid} <= v[6:4];
      {want.high_byte_enable_n, want.upper_addr} <= v[3:0];
      want.cmd_strobe_n <= 1'b0;
      settle();
      rd(hcs_pkg::OFS_SWITCH, 33'(v[6:0]));
      want.cmd_strobe_n <= 1'b1;
      want.upper_addr <= ~v[2:0];
      settle();
      chk(33'(switch_value), 33'(v[6:0]));
    end
    @(posedge mclk);
    {want.refresh_cycle_n, want.high_byte_enable_n, want.upper_addr} <= 5'h19;
    want.cmd_strobe_n <= 1'b0;
    settle();
    want.cmd_strobe_n <= 1'b1;
    wr(hcs_pkg::OFS_EXT_ID, 32'h9);
    settle();
    rd(hcs_pkg::OFS_STATUS, 33'h0F);
    chk(33'(host_respond), 33'h1);
    wr(hcs_pkg::OFS_EXT_ID, 32'h3);
    settle();
    rd(hcs_pkg::OFS_STATUS, 33'h09);
    chk(33'(host_respond), 33'h0);
    wr(hcs_pkg::OFS_EXT_ID, 32'h9);
    want.refresh_cycle_n <= 1'b0;
    settle();
    chk(33'(host_respond), 33'h0);
    want.refresh_cycle_n <= 1'b1;
    want.high_byte_enable_n <= 1'b0;
    settle();
    chk(33'(wide_transfer), 33'h1);
    want.high_byte_enable_n <= 1'b1;
    {want.upper_addr, want.host_addr15, want.high_address_valid} <= 5'h11;
    want.mem_read_n <= 1'b0;
    settle();
    chk(33'(wide_transfer), 33'h0);
    chk(33'({bios_rom_select_n, xcvr_enable_n}), 33'h0);
    want.host_addr15 <= 1'b1;
    settle();
    chk(33'(bios_rom_select_n), 33'h1);
    for (int s = 0; s < 4; s++) begin
      wr(hcs_pkg::OFS_MISC_OUT, 32'(s) << hcs_pkg::MISC_CLK_LSB);
      repeat (3) begin
        @(negedge mclk);
        #0.05;
        chk(33'(dot_clock_sel), 33'((s == 0) ? ca : (s == 1) ? cb : cc));
      end
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      mem_offset <= 18'($urandom);
      repeat (2) @(posedge mclk);
      chk(33'($countones(dram_chip_en)), 33'h2);
      chk(33'(dram_plane), 33'(mem_offset[17:16]));
      chk(33'(dram_addr), 33'(mem_offset[15:0]));
      chk(33'(dram_chip_en), 33'(8'(8'h03 << (2 * mem_offset[17:16]))));
    end
    want.strap <= 1'b0;
    want.host_addr15 <= 1'b0;
    rst();
    chk(33'({isa_mode, bios_rom_select_n}), 33'h1);
    rd(hcs_pkg::OFS_STATUS, 33'h06);
    test_done();
  end
endmodule
